// *** design/udsc_defs.vh ***
`ifndef UDSC_DEFS_VH
`define UDSC_DEFS_VH

`define UDSC_ADDR_W        8
`define UDSC_OFF_FRAME     8'h00
`define UDSC_OFF_IDENT     8'h04
`define UDSC_OFF_STATUS    8'h08
`define UDSC_OFF_CTRL      8'h0c

`define UDSC_FRM_LSB       0
`define UDSC_FRM_MSB       10
`define UDSC_MATCH_LSB     16
`define UDSC_MATCH_MSB     26
`define UDSC_VER_LSB       0
`define UDSC_VER_MSB       11
`define UDSC_REL_LSB       12
`define UDSC_REL_MSB       15
`define UDSC_SR_RST_BIT    8
`define UDSC_SR_SUSPENDED_FLAG_BIT   7
`define UDSC_SR_CFG_LSB    5
`define UDSC_SR_CFG_MSB    6
`define UDSC_SR_SELECTED_IF_INDEX_LSB   3
`define UDSC_SR_SELECTED_IF_INDEX_MSB   4
`define UDSC_SR_ALT_LSB    0
`define UDSC_SR_ALT_MSB    2
`define UDSC_CR_DONE_BIT   6
`define UDSC_CR_ERR_BIT    5

`define UDSC_FRM_RST       11'h000
`define UDSC_MATCH_RST     11'h000
`define UDSC_VER_1_0       12'h100
`define UDSC_VER_1_1       12'h110
`define UDSC_VER_2_0       12'h200
`define UDSC_REL_RST       4'h1

`define UDSC_HS_BUSY       2'h0
`define UDSC_HS_ACK        2'h1
`define UDSC_HS_ERR        2'h2

`define UDSC_ANSWER_CYC    1

`endif

// *** design/udsc_apb_decode.v ***
`timescale 1ns/1ns
`include "udsc_defs.vh"

module udsc_apb_decode (
    psel,
    penable,
    pwrite,
    paddr,
    setup,
    sel_frame,
    sel_ident,
    sel_status,
    sel_ctrl,
    unmapped,
    wr_frame,
    wr_ctrl
);
    input  wire                      psel;
    input  wire                      penable;
    input  wire                      pwrite;
    input  wire [`UDSC_ADDR_W-1:0]   paddr;
    output wire                      setup;
    output wire                      sel_frame;
    output wire                      sel_ident;
    output wire                      sel_status;
    output wire                      sel_ctrl;
    output wire                      unmapped;
    output wire                      wr_frame;
    output wire                      wr_ctrl;

    function hit;
        input [`UDSC_ADDR_W-1:0] a;
        input [`UDSC_ADDR_W-1:0] off;
        begin
            hit = (a == off);
        end
    endfunction

    assign setup      = psel & ~penable;
    assign sel_frame  = hit(paddr, `UDSC_OFF_FRAME);
    assign sel_ident  = hit(paddr, `UDSC_OFF_IDENT);
    assign sel_status = hit(paddr, `UDSC_OFF_STATUS);
    assign sel_ctrl   = hit(paddr, `UDSC_OFF_CTRL);
    assign unmapped   = ~(sel_frame | sel_ident | sel_status | sel_ctrl);
    // access-phase write strobes; the top gates them with pready
    assign wr_frame   = psel & penable & pwrite & sel_frame;
    assign wr_ctrl    = psel & penable & pwrite & sel_ctrl;

endmodule // udsc_apb_decode

// *** design/udsc_frame_match.v ***
`timescale 1ns/1ns
`include "udsc_defs.vh"

module udsc_frame_match (
    pclk,
    presetn,
    sof_valid,
    sof_frame_num,
    match_val,
    match_mask,
    frame_q,
    match_irq_q
);
    input  wire         pclk;
    input  wire         presetn;
    input  wire         sof_valid;
    input  wire [10:0]  sof_frame_num;
    input  wire [10:0]  match_val;
    input  wire         match_mask;
    output reg  [10:0]  frame_q;
    output reg          match_irq_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_q     <= `UDSC_FRM_RST;
            match_irq_q <= 1'b0;
        end else begin
            if (sof_valid) begin
                frame_q <= sof_frame_num;
            end
            // one pulse per captured frame that hits the compare value while match_mask is low
            match_irq_q <= sof_valid & ~match_mask &
                           (sof_frame_num == match_val);
        end
    end

endmodule // udsc_frame_match

// *** design/udsc_status_ctrl.v ***
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "udsc_defs.vh"

module udsc_status_ctrl (
    pclk,
    presetn,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    sof_valid,
    sof_frame_num,
    match_irq_mask,
    bus_reset_sig,
    bus_suspended,
    host_config,
    selected_if_index,
    alternate_setting_sel,
    status_phase_done,
    frame_match_irq,
    handshake_code,
    request_done,
    request_error
);
    parameter [3:0] SILICON_RELEASE = `UDSC_REL_RST; // arbitrary value
    parameter [11:0] STD_VERSION    = `UDSC_VER_1_1;

    input  wire                      pclk;
    input  wire                      presetn;
    input  wire                      psel;
    input  wire                      penable;
    input  wire                      pwrite;
    input  wire [`UDSC_ADDR_W-1:0]   paddr;
    input  wire [31:0]               pwdata;
    output wire [31:0]               prdata;
    output wire                      pready;
    output wire                      pslverr;
    input  wire                      sof_valid;
    input  wire [10:0]               sof_frame_num;
    input  wire                      match_irq_mask;
    input  wire                      bus_reset_sig;
    input  wire                      bus_suspended;
    input  wire [1:0]                host_config;
    input  wire [1:0]                selected_if_index;
    input  wire [2:0]                alternate_setting_sel;
    input  wire                      status_phase_done;
    output wire                      frame_match_irq;
    output wire [1:0]                handshake_code;
    output wire                      request_done;
    output wire                      request_error;

    // bus handshake state
    localparam [1:0] ST_IDLE   = 2'h0;
    localparam [1:0] ST_ACCESS = 2'h1;
    localparam [1:0] ST_WAIT   = 2'h2;

    reg  [1:0]   state_q;
    reg  [1:0]   state_d;
    reg  [31:0]  prdata_q;
    reg  [31:0]  prdata_d;
    reg          pready_q;
    reg          pslverr_q;
    reg  [10:0]  match_q;
    reg          done_q;
    reg          done_d;
    reg          err_q;
    reg          err_d;
    reg  [1:0]   hs_q;
    reg  [1:0]   hs_d;
    reg          sr_rst_q;
    reg          sr_suspended_flag_q;
    reg  [1:0]   sr_cfg_q;
    reg  [1:0]   sr_selected_if_index_q;
    reg  [2:0]   sr_alt_q;
    reg          pready_d;
    reg          pslverr_d;
    reg  [31:0]  frame_word;
    reg  [31:0]  ident_word;
    reg  [31:0]  status_word;
    reg  [31:0]  ctrl_word;

    wire         setup;
    wire         sel_frame;
    wire         sel_ident;
    wire         sel_status;
    wire         sel_ctrl;
    wire         unmapped;
    wire         wr_frame;
    wire         wr_ctrl;
    wire [10:0]  frame_q;
    wire         match_irq_q;
    wire         access_hit;
    wire         frame_wr_go;
    wire         ctrl_wr_go;
    wire         rd_setup;

    udsc_apb_decode u_dec (
        .psel       (psel),
        .penable    (penable),
        .pwrite     (pwrite),
        .paddr      (paddr),
        .setup      (setup),
        .sel_frame  (sel_frame),
        .sel_ident  (sel_ident),
        .sel_status (sel_status),
        .sel_ctrl   (sel_ctrl),
        .unmapped   (unmapped),
        .wr_frame   (wr_frame),
        .wr_ctrl    (wr_ctrl)
    );

    udsc_frame_match u_frm (
        .pclk          (pclk),
        .presetn       (presetn),
        .sof_valid     (sof_valid),
        .sof_frame_num (sof_frame_num),
        .match_val     (match_q),
        .match_mask    (match_irq_mask),
        .frame_q       (frame_q),
        .match_irq_q   (match_irq_q)
    );

    // a write lands only at the edge where pready is sampled high
    assign access_hit  = psel & penable & pready_q;
    assign frame_wr_go = wr_frame & access_hit;
    assign ctrl_wr_go  = wr_ctrl & access_hit;
    assign rd_setup    = setup & ~pwrite;

    // register images; reserved positions read as zero
    always @* begin
        frame_word  = 32'h00000000;
        ident_word  = 32'h00000000;
        status_word = 32'h00000000;
        ctrl_word   = 32'h00000000;
        frame_word[`UDSC_FRM_MSB:`UDSC_FRM_LSB] = frame_q;
        frame_word[`UDSC_MATCH_MSB:`UDSC_MATCH_LSB] = match_q;
        ident_word[`UDSC_VER_MSB:`UDSC_VER_LSB] = STD_VERSION;
        ident_word[`UDSC_REL_MSB:`UDSC_REL_LSB] = SILICON_RELEASE;
        status_word[`UDSC_SR_RST_BIT] = sr_rst_q;
        status_word[`UDSC_SR_SUSPENDED_FLAG_BIT] = sr_suspended_flag_q;
        status_word[`UDSC_SR_CFG_MSB:`UDSC_SR_CFG_LSB] = sr_cfg_q;
        status_word[`UDSC_SR_SELECTED_IF_INDEX_MSB:`UDSC_SR_SELECTED_IF_INDEX_LSB] = sr_selected_if_index_q;
        status_word[`UDSC_SR_ALT_MSB:`UDSC_SR_ALT_LSB] = sr_alt_q;
        ctrl_word[`UDSC_CR_DONE_BIT] = done_q;
        ctrl_word[`UDSC_CR_ERR_BIT] = err_q;
    end

    // read data mux, evaluated in the setup cycle
    always @* begin
        prdata_d = 32'h00000000;
        case (1'b1)
            sel_frame: begin
                prdata_d = frame_word;
            end
            sel_ident: begin
                prdata_d = ident_word;
            end
            sel_status: begin
                prdata_d = status_word;
            end
            sel_ctrl: begin
                prdata_d = ctrl_word;
            end
            default: begin
                prdata_d = 32'h00000000;
            end
        endcase
    end

    // zero-wait answer: pready rises in the first access cycle
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (setup) begin
                    state_d = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (psel & ~penable) begin
                    state_d = ST_ACCESS;
                end else begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (setup) begin
                    state_d = ST_ACCESS;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // answer in the first access cycle; unmapped gets an error
    always @* begin
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (state_d == ST_ACCESS) begin
            pready_d  = 1'b1;
            pslverr_d = unmapped;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= ST_IDLE;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // read data stands while psel stays high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h00000000;
        end else if (rd_setup) begin
            prdata_q <= prdata_d;
        end else if (~psel) begin
            prdata_q <= 32'h00000000;
        end
    end

    // compare value; frame field and reserved bits ignore writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_q <= `UDSC_MATCH_RST;
        end else if (frame_wr_go) begin
            match_q <= pwdata[`UDSC_MATCH_MSB:`UDSC_MATCH_LSB];
        end
    end

    // bus-level flags sampled from the core; no write path exists
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_rst_q  <= 1'b0;
            sr_suspended_flag_q <= 1'b0;
        end else begin
            sr_rst_q  <= bus_reset_sig;
            sr_suspended_flag_q <= bus_suspended;
        end
    end

    // host selections sampled from the core; no write path exists
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sr_cfg_q  <= 2'h0;
            sr_selected_if_index_q <= 2'h0;
            sr_alt_q  <= 3'h0;
        end else begin
            sr_cfg_q  <= host_config;
            sr_selected_if_index_q <= selected_if_index;
            sr_alt_q  <= alternate_setting_sel;
        end
    end

    // request-done: a software set in the same cycle beats the clear
    always @* begin
        done_d = done_q;
        err_d  = err_q;
        if (ctrl_wr_go) begin
            done_d = pwdata[`UDSC_CR_DONE_BIT];
            err_d  = pwdata[`UDSC_CR_ERR_BIT];
        end else if (status_phase_done) begin
            done_d = 1'b0;
        end
    end

    // status-phase handshake from both bits
    always @* begin
        hs_d = `UDSC_HS_BUSY;
        case ({done_d, err_d})
            2'b10: begin
                hs_d = `UDSC_HS_ACK;
            end
            2'b11: begin
                hs_d = `UDSC_HS_ERR;
            end
            default: begin
                hs_d = `UDSC_HS_BUSY;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
            err_q  <= 1'b0;
        end else begin
            done_q <= done_d;
            err_q  <= err_d;
        end
    end

    // handshake register moves on the same edge as the bits
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_q <= `UDSC_HS_BUSY;
        end else begin
            hs_q <= hs_d;
        end
    end

    assign prdata          = prdata_q;
    assign pready          = pready_q;
    assign pslverr         = pslverr_q;
    assign frame_match_irq = match_irq_q;
    assign handshake_code  = hs_q;
    assign request_done    = done_q;
    assign request_error   = err_q;

endmodule // udsc_status_ctrl

// *** testbench/udsc_props.sv ***
`timescale 1ns/1ns
`include "udsc_defs.vh"

module udsc_props #(
    parameter [3:0]  SILICON_RELEASE = 4'h1,
    parameter [11:0] STD_VERSION     = 12'h110
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        sof_valid,
    input wire [10:0] sof_frame_num,
    input wire        match_irq_mask,
    input wire        bus_reset_sig,
    input wire        bus_suspended,
    input wire [1:0]  host_config,
    input wire [1:0]  selected_if_index,
    input wire [2:0]  alternate_setting_sel,
    input wire        status_phase_done,
    input wire        frame_match_irq,
    input wire [1:0]  handshake_code,
    input wire        request_done,
    input wire        request_error
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire       setup = psel && !penable;
    wire       rd    = pready && !pwrite;
    wire       cwr   = psel && penable && pready && pwrite && paddr == 8'h0c;
    reg [10:0] frm_q;
    reg [10:0] mt_q;

    // shadow of frame and compare fields
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frm_q <= 11'h000;
            mt_q  <= 11'h000;
        end else begin
            if (sof_valid)
                frm_q <= sof_frame_num;
            if (psel && penable && pready && pwrite && paddr == 8'h00)
                mt_q <= pwdata[26:16];
        end
    end

    chk_ready_next: assert property (setup |=> pready)
        else $error("no answer after setup");
    chk_ready_cause: assert property (pready |-> $past(setup))
        else $error("answer without setup");
    chk_unmapped_err: assert property (pready |-> pslverr ==
        !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c}))
        else $error("error response wrong");
    chk_ident_value: assert property (rd && paddr == 8'h04 |->
        prdata == {16'h0, SILICON_RELEASE, STD_VERSION})
        else $error("ident value wrong");
    chk_frame_read: assert property (rd && paddr == 8'h00 |->
        prdata == {5'h0, $past(mt_q), 5'h0, $past(frm_q)})
        else $error("frame register wrong");
    chk_status_read: assert property (rd && paddr == 8'h08 |->
        prdata == {23'h0, $past({bus_reset_sig, bus_suspended, host_config,
        selected_if_index, alternate_setting_sel}, 2)})
        else $error("status register wrong");
    chk_match_irq: assert property (frame_match_irq == $past(sof_valid &&
        !match_irq_mask && sof_frame_num == mt_q))
        else $error("match interrupt wrong");
    chk_ctrl_write: assert property (cwr |=> request_done == $past(pwdata[6])
        && request_error == $past(pwdata[5]))
        else $error("control write wrong");
    chk_done_clear: assert property (status_phase_done && !cwr |=>
        !request_done)
        else $error("done not cleared");
    chk_hs_code: assert property (handshake_code == (!request_done ?
        `UDSC_HS_BUSY : request_error ? `UDSC_HS_ERR : `UDSC_HS_ACK))
        else $error("handshake code wrong");
    chk_ctrl_read: assert property (rd && paddr == 8'h0c |->
        prdata == {25'h0, $past(request_done), $past(request_error),
        5'h0})
        else $error("control register wrong");
endmodule // udsc_props

bind udsc_status_ctrl udsc_props #(.SILICON_RELEASE(SILICON_RELEASE),
    .STD_VERSION(STD_VERSION)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sof_valid(sof_valid), .sof_frame_num(sof_frame_num),
    .match_irq_mask(match_irq_mask), .bus_reset_sig(bus_reset_sig),
    .bus_suspended(bus_suspended), .host_config(host_config),
    .selected_if_index(selected_if_index),
    .alternate_setting_sel(alternate_setting_sel),
    .status_phase_done(status_phase_done),
    .frame_match_irq(frame_match_irq), .handshake_code(handshake_code),
    .request_done(request_done), .request_error(request_error));

// *** testbench/udsc_core_model.sv ***
`timescale 1ns/1ns

module udsc_core_model (
    input  wire       pclk,
    output reg        sof_valid,
    output reg [10:0] sof_frame_num,
    output reg        bus_reset_sig,
    output reg        bus_suspended,
    output reg [1:0]  host_config,
    output reg [1:0]  selected_if_index,
    output reg [2:0]  alternate_setting_sel,
    output reg        status_phase_done
);
    initial begin
        sof_valid = 1'b0;
        sof_frame_num = 11'h000;
        {bus_reset_sig, bus_suspended, host_config} = 4'h0;
        {selected_if_index, alternate_setting_sel} = 5'h00;
        status_phase_done = 1'b0;
    end

    // number only valid with the strobe, scrambled after
    task sof(input [10:0] n);
        begin
            @(posedge pclk);
            sof_valid     <= 1'b1;
            sof_frame_num <= n;
            @(posedge pclk);
            sof_valid     <= 1'b0;
            sof_frame_num <= ~n;
        end
    endtask

    task set_bus(input [8:0] s);
        begin
            @(posedge pclk);
            {bus_reset_sig, bus_suspended, host_config, selected_if_index,
                alternate_setting_sel} <= s;
        end
    endtask

    task phase_end;
        begin
            @(posedge pclk);
            status_phase_done <= 1'b1;
            @(posedge pclk);
            status_phase_done <= 1'b0;
        end
    endtask
endmodule // udsc_core_model

// *** testbench/tb.sv ***
`timescale 1ns/1ns
`include "udsc_defs.vh"

module tb;
    reg         pclk, presetn, psel, penable, pwrite, match_irq_mask, er;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire        pready, pslverr, sof_valid, bus_reset_sig, bus_suspended;
    wire [10:0] sof_frame_num;
    wire [1:0]  host_config, selected_if_index, handshake_code;
    wire [2:0]  alternate_setting_sel;
    wire        status_phase_done, frame_match_irq;
    wire        request_done, request_error;
    wire [3:0]  req_view = {request_done, request_error, handshake_code};
    integer     miscompares, n_compared, i;

`define CMP(g, e) begin n_compared = n_compared + 1; \
    if ((g) !== (e)) begin miscompares = miscompares + 1; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end

    udsc_status_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sof_valid(sof_valid), .sof_frame_num(sof_frame_num),
        .match_irq_mask(match_irq_mask), .bus_reset_sig(bus_reset_sig),
        .bus_suspended(bus_suspended), .host_config(host_config),
        .selected_if_index(selected_if_index),
        .alternate_setting_sel(alternate_setting_sel),
        .status_phase_done(status_phase_done),
        .frame_match_irq(frame_match_irq), .handshake_code(handshake_code),
        .request_done(request_done), .request_error(request_error));

    udsc_core_model core (.pclk(pclk), .sof_valid(sof_valid),
        .sof_frame_num(sof_frame_num), .bus_reset_sig(bus_reset_sig),
        .bus_suspended(bus_suspended), .host_config(host_config),
        .selected_if_index(selected_if_index),
        .alternate_setting_sel(alternate_setting_sel),
        .status_phase_done(status_phase_done));

    task complete_run;
        begin
            if (miscompares == 0 && n_compared > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask

    task apb(input w, input [7:0] a, input [31:0] d);
        integer k;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && k < 20) begin
                @(posedge pclk);
                k = k + 1;
            end
            if (pready !== 1'b1) begin
                miscompares = miscompares + 1;
                complete_run;
            end
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task rdchk(input [7:0] a, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            `CMP({er, rd}, {1'b0, e})
        end
    endtask

    task t_reset;
        begin
            rdchk(8'h00, 32'h0);
            rdchk(8'h04, {16'h0, `UDSC_REL_RST, `UDSC_VER_1_1});
            rdchk(8'h08, 32'h0);
            rdchk(8'h0c, 32'h0);
            `CMP(handshake_code, `UDSC_HS_BUSY)
            apb(1'b1, 8'h04, 32'hffffffff);
            rdchk(8'h04, {16'h0, `UDSC_REL_RST, `UDSC_VER_1_1});
            apb(1'b1, 8'h10, 32'hffffffff);
            `CMP(er, 1'b1)
            apb(1'b0, 8'h10, 32'h0);
            `CMP({er, rd}, {1'b1, 32'h0})
        end
    endtask

    task t_frame;
        begin
            apb(1'b1, 8'h00, 32'hffffffff);
            rdchk(8'h00, 32'h07ff0000);
            apb(1'b1, 8'h00, 32'h01230000);
            core.sof(11'h122);
            #1 `CMP(frame_match_irq, 1'b0)
            core.sof(11'h123);
            #1 `CMP(frame_match_irq, 1'b1)
            @(posedge pclk);
            #1 `CMP(frame_match_irq, 1'b0)
            rdchk(8'h00, 32'h01230123);
            match_irq_mask <= 1'b1;
            core.sof(11'h123);
            #1 `CMP(frame_match_irq, 1'b0)
            match_irq_mask <= 1'b0;
            core.sof(11'h7ff);
            rdchk(8'h00, 32'h012307ff);
        end
    endtask

    // walking one through every status bit, plus a mixed pattern
    task t_status;
        reg [8:0] p;
        begin
            for (i = 0; i < 10; i = i + 1) begin
                p = (i == 9) ? 9'h0aa : (9'h001 << i);
                core.set_bus(p);
                apb(1'b1, 8'h08, 32'hffffffff);
                rdchk(8'h08, {23'h0, p});
            end
        end
    endtask

    task t_request;
        begin
            apb(1'b1, 8'h0c, 32'hffffffc0);
            #1 `CMP(req_view, 4'h9)
            rdchk(8'h0c, 32'h00000040);
            core.phase_end;
            #1 `CMP({request_done, handshake_code}, 3'h0)
            apb(1'b1, 8'h0c, 32'h00000020);
            #1 `CMP(req_view, 4'h4)
            apb(1'b1, 8'h0c, 32'h00000060);
            #1 `CMP(handshake_code, `UDSC_HS_ERR)
            core.phase_end;
            #1 `CMP({request_done, request_error}, 2'b01)
            rdchk(8'h0c, 32'h00000020);
            // software set and core clear on one edge: the write wins
            fork
                apb(1'b1, 8'h0c, 32'h00000040);
                begin
                    @(posedge pclk);
                    core.phase_end;
                end
            join
            #1 `CMP(req_view, 4'h9)
        end
    endtask

    // reset in mid-run clears compare value and request bits
    task t_rerun;
        begin
            apb(1'b1, 8'h00, 32'h03450000);
            apb(1'b1, 8'h0c, 32'h00000060);
            presetn <= 1'b0;
            repeat (2) @(posedge pclk);
            presetn <= 1'b1;
            rdchk(8'h00, 32'h0);
            rdchk(8'h0c, 32'h0);
            `CMP(handshake_code, `UDSC_HS_BUSY)
        end
    endtask

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    initial begin
        miscompares = 0;
        n_compared = 0;
        {presetn, psel, penable, pwrite, match_irq_mask} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_frame;
        t_status;
        t_request;
        t_rerun;
        complete_run;
    end
endmodule // tb
